// >>> timer_map.svh
// Register indices, field positions, reset values, reload start count and bus answer codes of the timer
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_COUNT_HIGH 12'hf00
`define IDX_COUNT_LOW 12'hf01
`define IDX_RELOAD_HIGH 12'hf02
`define IDX_RELOAD_LOW 12'hf03
`define IDX_CAPTURE_HIGH 12'hf04
`define IDX_CAPTURE_LOW 12'hf05
`define IDX_CONTROL 12'hf07
`define IDX_STATUS 12'hf08

// Control register fields
`define CTL_ENABLE_BIT 0
`define CTL_MODE_LSB 1
`define CTL_MODE_MSB 2
`define CTL_POLARITY_BIT 3
`define CTL_PRESCALE_LSB 4
`define CTL_PRESCALE_MSB 6
`define CTL_OUT_LEVEL_BIT 7
`define CTL_OUT_ENABLE_BIT 8
`define CTL_WIDTH 9

// Status register fields
`define STS_STARTED_BIT 0
`define STS_OUT_LEVEL_BIT 1
`define STS_INPUT_LEVEL_BIT 2

// Reset values
`define RST_COUNT 16'h0000
`define RST_RELOAD 16'hffff
`define RST_CAPTURE 16'h0000
`define RST_CONTROL 9'h000

// Count loaded at every reload
`define RELOAD_START 16'h0001

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// >>> timer_pkg.sv
// Types shared by the timer modules
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_GATED,
    MODE_CAPTURE_COMPARE
  } mode_e;

  typedef logic [15:0] count_t;

endpackage

// >>> timer_event_if.sv
// Carrier for prescale ticks and timer input events between timer modules
`timescale 1ns/1ns
interface timer_event_if;
  logic tick;
  logic level;
  logic rise;
  logic fall;

  modport prescaler (output tick);
  modport sampler (output level, output rise, output fall);
  modport core (input tick, input level, input rise, input fall);
endinterface

// >>> timer_prescaler.sv
// Prescaler giving one tick every 2^n system clocks while the timer runs
`timescale 1ns/1ns
module timer_prescaler #(
  parameter int PRESCALE_BITS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [PRESCALE_BITS-1:0] prescale,
  timer_event_if.prescaler evt
);
  localparam int DIV_BITS = (1 << PRESCALE_BITS) - 1;

  logic [DIV_BITS-1:0] div;

  function automatic logic [DIV_BITS-1:0] div_mask(input logic [PRESCALE_BITS-1:0] n);
    logic [DIV_BITS:0] one;
    one = '0;
    one[n] = 1'b1;
    div_mask = DIV_BITS'(one - 1'b1);
  endfunction

  // Restart on enable so the first pass has its full length
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div <= '0;
    end else if ((div & div_mask(prescale)) == div_mask(prescale)) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  assign evt.tick = run && ((div & div_mask(prescale)) == div_mask(prescale));
endmodule

// >>> timer_input_sampler.sv
// Two-stage synchroniser and edge detector for the timer input pin
`timescale 1ns/1ns
module timer_input_sampler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  timer_event_if.sampler evt
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign evt.level = sync;
  assign evt.rise = sync && !last;
  assign evt.fall = !sync && last;
endmodule

// >>> timer_capture_compare_gated.sv
// Timer with capture, compare, gated and capture/compare modes behind AXI4-Lite
// Contract
// - Capture mode: selected input edge copies count into capture pair.
// - Capture mode: polarity bit picks rising or falling capture edge.
// - Capture mode: each capture interrupts; counter keeps counting, not reset.
// - Capture mode: count reaching reload interrupts and keeps counting.
// - Compare mode: count equal to compare value interrupts, no reset.
// - Compare mode: output enabled toggles at each compare match.
// - Compare mode: count wraps from ffff to 0000 and continues.
// - Gated mode: counts only while input is at polarity-selected level.
// - Gated mode: interrupt when input leaves active level, and on reload.
// - Gated mode: at reload interrupt, load 0001, resume if gate active.
// - Gated mode: output enabled toggles at each reload.
// - Gated mode: written start count applies to first pass only.
// - Capture/compare: idle until first qualifying edge; it starts silently.
// - Capture/compare: later edges capture, interrupt, load 0001, continue.
// - Capture/compare: reaching compare value interrupts, loads 0001, continues.
// - Enabled: high byte read latches low byte; low read returns it.
// - Disabled: low byte read returns live counter.
// - Count reads never disturb counting, interrupts or output.
// - Counter advances on system clock divided by prescale factor.
// - Output toggles at each counter reload where a mode reloads.
// - Reload high write is held; low write commits both bytes.
// - Count byte write loads that byte next edge; counting continues.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "timer_map.svh"
module timer_capture_compare_gated
  import timer_pkg::*;
#(
  parameter int ADDR_WIDTH = 14,
  parameter int PRESCALE_BITS = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_en,
  output logic timer_irq
);
  timer_event_if evt ();

  // Registers
  count_t count;
  count_t reload;
  count_t capture;
  logic [7:0] reload_high_hold;
  logic [7:0] count_low_hold;
  logic [`CTL_WIDTH-1:0] control;
  logic started;

  // Bus write side
  logic aw_full;
  logic w_full;
  logic [11:0] aw_index;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_lane0;
  logic wr_lane1;

  // Datapath
  count_t next_count;
  count_t next_capture;
  logic next_started;
  logic irq_event;
  logic toggle_event;
  logic enable;
  mode_e mode;
  logic polarity;
  logic trigger_edge;
  logic gate_active;
  logic gate_release;
  logic [11:0] ar_index;
  logic ar_fire;

  function automatic logic [11:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
    reg_index = 12'(addr >> 2);
  endfunction

  function automatic logic is_mapped(input logic [11:0] idx);
    is_mapped = (idx >= `IDX_COUNT_HIGH && idx <= `IDX_CAPTURE_LOW)
      || idx == `IDX_CONTROL || idx == `IDX_STATUS;
  endfunction

  assign enable = control[`CTL_ENABLE_BIT];
  assign mode = mode_e'(control[`CTL_MODE_MSB:`CTL_MODE_LSB]);
  assign polarity = control[`CTL_POLARITY_BIT];

  timer_prescaler #(
    .PRESCALE_BITS(PRESCALE_BITS)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(enable),
    .prescale(control[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB]),
    .evt(evt.prescaler)
  );

  timer_input_sampler u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(timer_in),
    .evt(evt.sampler)
  );

  // Input qualification by polarity
  assign trigger_edge = polarity ? evt.rise : evt.fall;
  assign gate_active = (evt.level == polarity);
  assign gate_release = polarity ? evt.fall : evt.rise;

  // Write channel: address and data are taken in either order
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && w_strb[0];
  assign wr_lane1 = wr_fire && w_strb[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_index <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_index <= reg_index(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_index) && aw_index != `IDX_STATUS ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one outstanding read, answered the cycle after it is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign ar_index = reg_index(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(ar_index) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (ar_index)
        `IDX_COUNT_HIGH: s_axi_rdata <= {24'h000000, count[15:8]};
        `IDX_COUNT_LOW: s_axi_rdata <= {24'h000000, enable ? count_low_hold : count[7:0]};
        `IDX_RELOAD_HIGH: s_axi_rdata <= {24'h000000, reload[15:8]};
        `IDX_RELOAD_LOW: s_axi_rdata <= {24'h000000, reload[7:0]};
        `IDX_CAPTURE_HIGH: s_axi_rdata <= {24'h000000, capture[15:8]};
        `IDX_CAPTURE_LOW: s_axi_rdata <= {24'h000000, capture[7:0]};
        `IDX_CONTROL: s_axi_rdata <= {23'h000000, control};
        `IDX_STATUS: s_axi_rdata <= {29'h00000000, evt.level, timer_out, started};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Low byte snapshot taken by a high byte read; the counter itself is untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_low_hold <= 8'h00;
    end else if (ar_fire && ar_index == `IDX_COUNT_HIGH && enable) begin
      count_low_hold <= count[7:0];
    end
  end

  // Counting, capture and reload events for each mode
  always_comb begin
    next_count = count;
    next_capture = capture;
    next_started = started;
    irq_event = 1'b0;
    toggle_event = 1'b0;
    if (wr_lane0 && aw_index == `IDX_CAPTURE_HIGH) begin
      next_capture[15:8] = w_data[7:0];
    end
    if (wr_lane0 && aw_index == `IDX_CAPTURE_LOW) begin
      next_capture[7:0] = w_data[7:0];
    end
    if (!enable) begin
      next_started = 1'b0;
    end else begin
      unique case (mode)
        MODE_CAPTURE: begin
          if (trigger_edge) begin
            next_capture = count;
            irq_event = 1'b1;
          end
          if (evt.tick) begin
            if (count == reload) begin
              irq_event = 1'b1;
            end
            next_count = count + 16'h0001;
          end
        end
        MODE_COMPARE: begin
          if (evt.tick) begin
            if (count == reload) begin
              irq_event = 1'b1;
              toggle_event = 1'b1;
            end
            next_count = count + 16'h0001;
          end
        end
        MODE_GATED: begin
          if (gate_release) begin
            irq_event = 1'b1;
          end
          if (evt.tick && gate_active) begin
            if (count == reload) begin
              next_count = `RELOAD_START;
              irq_event = 1'b1;
              toggle_event = 1'b1;
            end else begin
              next_count = count + 16'h0001;
            end
          end
        end
        MODE_CAPTURE_COMPARE: begin
          if (!started) begin
            if (trigger_edge) begin
              next_started = 1'b1;
            end
          end else if (trigger_edge) begin
            // An edge outranks a tick that would compare in the same cycle
            next_capture = count;
            next_count = `RELOAD_START;
            irq_event = 1'b1;
            toggle_event = 1'b1;
          end else if (evt.tick) begin
            if (count == reload) begin
              next_count = `RELOAD_START;
              irq_event = 1'b1;
              toggle_event = 1'b1;
            end else begin
              next_count = count + 16'h0001;
            end
          end
        end
      endcase
    end
    // A byte write lands on the next edge and counting resumes from it
    if (wr_lane0 && aw_index == `IDX_COUNT_HIGH) begin
      next_count[15:8] = w_data[7:0];
    end
    if (wr_lane0 && aw_index == `IDX_COUNT_LOW) begin
      next_count[7:0] = w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `RST_COUNT;
      capture <= `RST_CAPTURE;
      started <= 1'b0;
    end else begin
      count <= next_count;
      capture <= next_capture;
      started <= next_started;
    end
  end

  // Reload value changes as one 16-bit word on the low byte write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_high_hold <= 8'(`RST_RELOAD >> 8);
      reload <= `RST_RELOAD;
    end else if (wr_lane0 && aw_index == `IDX_RELOAD_HIGH) begin
      reload_high_hold <= w_data[7:0];
    end else if (wr_lane0 && aw_index == `IDX_RELOAD_LOW) begin
      reload <= {reload_high_hold, w_data[7:0]};
    end
  end

  // Control; the output level bit is also the live output state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= `RST_CONTROL;
    end else begin
      if (wr_lane0 && aw_index == `IDX_CONTROL) begin
        control[7:0] <= w_data[7:0];
      end
      if (wr_lane1 && aw_index == `IDX_CONTROL) begin
        control[`CTL_OUT_ENABLE_BIT] <= w_data[`CTL_OUT_ENABLE_BIT];
      end
      if (toggle_event && control[`CTL_OUT_ENABLE_BIT]) begin
        control[`CTL_OUT_LEVEL_BIT] <= !control[`CTL_OUT_LEVEL_BIT];
      end
    end
  end

  assign timer_out = control[`CTL_OUT_LEVEL_BIT];
  assign timer_out_en = control[`CTL_OUT_ENABLE_BIT];

  // Events in one cycle merge into a single request pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= irq_event;
    end
  end
endmodule

// >>> timer_ccg_assertions.sv
// Checker for the timer bus handshakes, interrupt pulse and output pin
`timescale 1ns/1ns
module timer_ccg_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_out,
  input wire logic timer_out_en,
  input wire logic timer_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_single_pulse_a: assert property (timer_irq |=> !timer_irq)
    else $error("irq high for more than one cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // Both halves are held for one cycle before the write executes
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Output may only move by a toggle with the function enabled or by a control write
  out_toggle_a: assert property (
    $changed(timer_out) |-> $past(timer_out_en) || $rose(s_axi_bvalid))
    else $error("output moved without cause");

  irq_seen_c: cover property (timer_irq);
  toggle_seen_c: cover property (timer_out_en && $changed(timer_out));
  read_seen_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind timer_capture_compare_gated timer_ccg_assertions chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer_out,
  .timer_out_en, .timer_irq);

// >>> timer_pin_model.sv
// Behavioural source of the timer input pin
`timescale 1ns/1ns
module timer_pin_model (
  input wire logic aclk,
  output logic pin
);
  initial pin = 1'h0;
  // Moves just after an edge; the device treats the pin as asynchronous anyway
  task automatic drive(input logic v);
    @(posedge aclk);
    pin <= v;
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the timer block
`timescale 1ns/1ns
`include "timer_map.svh"
module tb_top;
  typedef struct {logic [11:0] i; logic [31:0] d; logic [1:0] r;} row_s;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [13:0] awaddr = 14'h0;
  logic [13:0] araddr = 14'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, tout, toen, irq, pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d, h, l, c;
  int n_errors = 0;
  int total_checks = 0;
  int k;
  row_s rows[9] = '{'{`IDX_COUNT_HIGH, 32'h0, 2'h0}, '{`IDX_COUNT_LOW, 32'h0, 2'h0},
    '{`IDX_RELOAD_HIGH, 32'hff, 2'h0}, '{`IDX_RELOAD_LOW, 32'hff, 2'h0},
    '{`IDX_CAPTURE_HIGH, 32'h0, 2'h0}, '{`IDX_CAPTURE_LOW, 32'h0, 2'h0},
    '{`IDX_CONTROL, 32'h0, 2'h0}, '{`IDX_STATUS, 32'h0, 2'h0}, '{12'hf06, 32'h0, 2'h2}};

  always #20 aclk = ~aclk;

  timer_pin_model pm (.aclk, .pin);
  timer_capture_compare_gated dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_in(pin), .timer_out(tout), .timer_out_en(toen),
    .timer_irq(irq));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A late ready is raised only once the answer has been seen
  task automatic wr(input logic [11:0] i, input logic [31:0] v, input logic [1:0] er = 2'h0,
    input logic late = 1'h0);
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= !late;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && !bready) bready <= 1'h1;
    end while (bvalid !== 1'h1 || bready !== 1'h1);
    bready <= 1'h0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [11:0] i, output logic [31:0] v, input logic [1:0] er = 2'h0,
    input logic late = 1'h0);
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'h1;
    rready <= !late;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && !rready) rready <= 1'h1;
    end while (rvalid !== 1'h1 || rready !== 1'h1);
    v = rdata;
    rready <= 1'h0;
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  // Counts irq pulses over a window; each pulse is one cycle wide
  task automatic irqs(input int n);
    k = 0;
    repeat (n) begin
      @(posedge aclk);
      if (irq === 1'h1) k++;
    end
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic p, input logic e,
    input logic [2:0] s = 3'h0);
    return {23'h0, 1'h1, 1'h0, s, p, m, e};
  endfunction

  initial begin
    #(40 * 4000);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[j]) begin
      rd(rows[j].i, d, rows[j].r);
      chk("reset value", d, rows[j].d);
    end
    $display("test reset values done");
    wr(`IDX_RELOAD_HIGH, 32'h12, 2'h0, 1'h1);
    rd(`IDX_RELOAD_LOW, d, 2'h0, 1'h1);
    chk("reload low before commit", d, 32'hff);
    rd(`IDX_RELOAD_HIGH, d);
    chk("reload high before commit", d, 32'hff);
    wr(`IDX_RELOAD_LOW, 32'h34);
    rd(`IDX_RELOAD_HIGH, d);
    chk("reload high committed", d, 32'h12);
    wr(12'hf06, 32'h1, 2'h2);
    wr(`IDX_STATUS, 32'h7, 2'h2);
    // Output enable sits in byte lane one and must ignore a lane zero write
    wstrb <= 4'h1;
    wr(`IDX_CONTROL, 32'h100);
    wstrb <= 4'hf;
    chk("lane one masked", 32'(toen), 0);
    $display("test registers done");
    // Start just below the wrap so the match needs the roll-over
    wr(`IDX_COUNT_HIGH, 32'hff);
    wr(`IDX_COUNT_LOW, 32'hfd);
    wr(`IDX_RELOAD_HIGH, 32'h0);
    wr(`IDX_RELOAD_LOW, 32'h2);
    wr(`IDX_CONTROL, ctl(2'h1, 1'h0, 1'h1));
    irqs(20);
    chk("compare irqs", k, 1);
    chk("compare toggle", 32'(tout), 1);
    chk("output enabled", 32'(toen), 1);
    rd(`IDX_COUNT_HIGH, h);
    chk("wrapped high", h, 0);
    rd(`IDX_COUNT_LOW, l);
    rd(`IDX_COUNT_LOW, c);
    chk("latched low", c, l);
    wr(`IDX_CONTROL, ctl(2'h1, 1'h0, 1'h0));
    rd(`IDX_COUNT_LOW, c);
    chk("live low", 32'(c != l), 1);
    $display("test compare done");
    // Divide by four: the match on count 2 comes on the third tick
    wr(`IDX_COUNT_HIGH, 32'h0);
    wr(`IDX_COUNT_LOW, 32'h0);
    wr(`IDX_CONTROL, ctl(2'h1, 1'h0, 1'h1, 3'h2));
    irqs(11);
    chk("prescaled early", k, 0);
    irqs(1);
    chk("prescaled match", k, 1);
    wr(`IDX_CONTROL, 32'h0);
    $display("test prescale done");
    wr(`IDX_CAPTURE_HIGH, 32'h0);
    wr(`IDX_CAPTURE_LOW, 32'h0);
    wr(`IDX_CONTROL, ctl(2'h0, 1'h1, 1'h1));
    pm.drive(1'h1);
    irqs(10);
    chk("capture irqs", k, 1);
    rd(`IDX_CAPTURE_HIGH, h);
    rd(`IDX_CAPTURE_LOW, l);
    rd(`IDX_COUNT_HIGH, c);
    rd(`IDX_COUNT_LOW, d);
    chk("captured", 32'({h[7:0], l[7:0]} != 0), 1);
    chk("running", 32'({c[7:0], d[7:0]} > {h[7:0], l[7:0]}), 1);
    pm.drive(1'h0);
    irqs(10);
    chk("falling edge ignored", k, 0);
    $display("test capture done");
    wr(`IDX_CONTROL, 32'h0);
    wr(`IDX_COUNT_HIGH, 32'h0);
    wr(`IDX_COUNT_LOW, 32'h0);
    wr(`IDX_RELOAD_HIGH, 32'h0);
    wr(`IDX_RELOAD_LOW, 32'h10);
    wr(`IDX_CONTROL, ctl(2'h2, 1'h1, 1'h1));
    irqs(8);
    rd(`IDX_COUNT_HIGH, h);
    rd(`IDX_COUNT_LOW, l);
    chk("gate closed", 32'(k) | l, 0);
    pm.drive(1'h1);
    irqs(24);
    chk("gated reload irqs", k, 1);
    chk("gated toggle", 32'(tout), 1);
    pm.drive(1'h0);
    irqs(8);
    chk("gate release irq", k, 1);
    rd(`IDX_COUNT_HIGH, h);
    rd(`IDX_COUNT_LOW, l);
    chk("second pass", 32'({h[7:0], l[7:0]} inside {[1:15]}), 1);
    $display("test gated done");
    wr(`IDX_CONTROL, 32'h0);
    wr(`IDX_COUNT_LOW, 32'h0);
    wr(`IDX_RELOAD_HIGH, 32'h1);
    wr(`IDX_RELOAD_LOW, 32'h0);
    wr(`IDX_CONTROL, ctl(2'h3, 1'h1, 1'h1));
    pm.drive(1'h1);
    irqs(10);
    chk("first edge silent", k, 0);
    pm.drive(1'h0);
    pm.drive(1'h1);
    irqs(10);
    chk("capture reload irq", k, 1);
    rd(`IDX_COUNT_HIGH, h);
    rd(`IDX_COUNT_LOW, l);
    chk("count restarted", 32'({h[7:0], l[7:0]} < 16'h10), 1);
    // Eleven ticks pass between the starting edge and the capturing edge
    rd(`IDX_CAPTURE_LOW, c);
    chk("cc capture", c, 32'h0b);
    irqs(300);
    chk("compare reload irq", k, 1);
    $display("test capture compare done");
    finish_test();
  end
endmodule
